// ==== verilog/fbs_pkg.sv ====
/*
  Shared constants for the request/reply data unit server and client.
  Assumes both ends share one 25 MHz clock and one active-low reset.
*/
`default_nettype none
package fbs_pkg;
  localparam logic [7:0] FBS_FC_NONE       = 8'h00;
  localparam logic [7:0] FBS_FC_EXC_BIT    = 8'h80;
  localparam logic [7:0] FBS_FC_RD_COILS   = 8'h01;
  localparam logic [7:0] FBS_FC_RD_DISC    = 8'h02;
  localparam logic [7:0] FBS_FC_RD_HOLD    = 8'h03;
  localparam logic [7:0] FBS_FC_RD_INREG   = 8'h04;
  localparam logic [7:0] FBS_FC_WR_COIL    = 8'h05;
  localparam logic [7:0] FBS_FC_WR_REG     = 8'h06;
  localparam logic [7:0] FBS_FC_RD_EXCST   = 8'h07;
  localparam logic [7:0] FBS_FC_DIAG       = 8'h08;
  localparam logic [7:0] FBS_FC_WR_COILS   = 8'h0f;
  localparam logic [7:0] FBS_FC_WR_REGS    = 8'h10;
  localparam logic [7:0] FBS_FC_USR1_LO    = 8'h41;
  localparam logic [7:0] FBS_FC_USR1_HI    = 8'h48;
  localparam logic [7:0] FBS_FC_USR2_LO    = 8'h64;
  localparam logic [7:0] FBS_FC_USR2_HI    = 8'h6e;
  localparam logic [15:0] FBS_SUB_ECHO     = 16'h0000;
  localparam logic [15:0] FBS_SUB_CLRCNT   = 16'h000a;
  localparam logic [15:0] FBS_SUB_BUSCNT   = 16'h000b;
  localparam logic [7:0] FBS_EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0] FBS_EXC_ILL_ADDR  = 8'h02;
  localparam logic [7:0] FBS_EXC_ILL_VAL   = 8'h03;
  localparam logic [15:0] FBS_COIL_ON      = 16'hff00;
  localparam logic [15:0] FBS_COIL_OFF     = 16'h0000;
  // One overlaid word store: bits are the words' bits, LSB first
  localparam int          FBS_WORDS        = 16;
  localparam int          FBS_AW           = 4;
  localparam logic [15:0] FBS_BITS         = 16'h0100;
  localparam logic [15:0] FBS_MAX_RD_BITS  = 16'h07d0;
  localparam logic [15:0] FBS_MAX_RD_REGS  = 16'h007d;
  localparam logic [15:0] FBS_MAX_WR_BITS  = 16'h07b0;
  localparam logic [15:0] FBS_MAX_WR_REGS  = 16'h007b;
  localparam logic [8:0]  FBS_PDU_MAX      = 9'd253;
  localparam int          FBS_SER_ADU_MAX  = 256;
  localparam int          FBS_TCP_ADU_MAX  = 260;
  localparam logic [7:0]  FBS_EXC_STATUS   = 8'h00;
  localparam int          FBS_TMO_US       = 100;
  localparam int          FBS_CLK_MHZ      = 25;
  localparam int          FBS_TMO_CYC      = FBS_TMO_US * FBS_CLK_MHZ;
endpackage : fbs_pkg
`default_nettype wire

// ==== verilog/fbs_link_if.sv ====
/*
  Byte streams between client and server, valid/ready, with last marker.
  Assumes one clock; the testbench joins both ends through this interface.
*/
`timescale 1ns/1ps
`default_nettype none
interface fbs_link_if;
  logic [7:0] req_data;
  logic       req_valid;
  logic       req_last;
  logic       req_ready;
  logic [7:0] rsp_data;
  logic       rsp_valid;
  logic       rsp_last;
  logic       rsp_ready;
  modport server (input req_data, req_valid, req_last, rsp_ready,
                  output req_ready, rsp_data, rsp_valid, rsp_last);
  modport client (output req_data, req_valid, req_last, rsp_ready,
                  input req_ready, rsp_data, rsp_valid, rsp_last);
endinterface : fbs_link_if
`default_nettype wire

// ==== verilog/fbs_server.sv ====
/*
  Server end: collects a request unit, acts on the overlaid data store and
  streams back a normal or exception response through a two-entry buffer.
  Assumes requests arrive as byte streams closed by req_last.
*/
// How it works
// - Function code is one byte, 1..127
// - Code zero is answered as unsupported
// - Normal answer echoes the request code
// - Failure answer sets code bit seven
// - Exception code byte follows modified code
// - Units over 253 bytes are refused
// - Serial unit: address, unit, check, 256
// - TCP unit: seven-byte header, unit, 260
// - Empty data field accepted where enough
// - Wide fields travel high byte first
// - Four tables: bits and words, ro/rw
// - Addresses are zero-based 16-bit indices
// - Element X travels as address X-1
// - Tables overlay one shared word store
// - Accesses cover consecutive items, bounded count
// - Client initiates; server only answers
// - Good request returns data, else exception
// - Diagnostics sub-function selects the action
// - Client runs a response timeout
// - User-defined codes accepted as custom actions
`timescale 1ns/1ps
`default_nettype none
module fbs_server
  import fbs_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  fbs_link_if.server       link,
  input  wire logic [15:0] in_bits_in,
  output logic      [15:0] coil_word_out,
  output logic             busy_out
);
  typedef enum logic [3:0] {
    FBS_S_RX   = 4'b0001,
    FBS_S_EXEC = 4'b0010,
    FBS_S_TX   = 4'b0100,
    FBS_S_DROP = 4'b1000
  } fbs_srv_st_t;

  fbs_srv_st_t st_r, st_nxt;
  logic [7:0]  rq_r [0:5];
  logic [7:0]  rq_nxt [0:5];
  logic [8:0]  cnt_r, cnt_nxt;
  logic        big_r, big_nxt;
  logic [15:0] mem_r [0:FBS_WORDS-1];
  logic [15:0] mem_nxt [0:FBS_WORDS-1];
  logic [15:0] evc_r, evc_nxt;
  logic [7:0]  fc_r, fc_nxt;
  logic [7:0]  exc_r, exc_nxt;
  logic [15:0] a_r, a_nxt;
  logic [15:0] n_r, n_nxt;
  logic [2:0]  ph_r, ph_nxt;
  logic        odd_r, odd_nxt;
  logic [7:0]  bc_r, bc_nxt;
  logic        bv;
  logic [7:0]  bd;
  logic        bl;
  logic        brdy;

  // Bit b of the overlay lives in word b[7:4], bit b[3:0]
  function automatic logic bit_at(input logic [15:0] m [0:FBS_WORDS-1],
                                  input logic [15:0] a);
    bit_at = m[a[7:4]][a[3:0]];
  endfunction : bit_at

  logic [15:0] ra, rn, re;
  always_comb begin
    ra = {rq_r[1], rq_r[2]};
    rn = {rq_r[3], rq_r[4]};
    re = ra + rn;
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    big_nxt = big_r;
    evc_nxt = evc_r;
    fc_nxt = fc_r;
    exc_nxt = exc_r;
    a_nxt = a_r;
    n_nxt = n_r;
    ph_nxt = ph_r;
    odd_nxt = odd_r;
    bc_nxt = bc_r;
    bv = 1'b0;
    bd = 8'h00;
    bl = 1'b0;
    for (int i = 0; i < 6; i++) rq_nxt[i] = rq_r[i];
    for (int i = 0; i < FBS_WORDS; i++) mem_nxt[i] = mem_r[i];
    // The shared store also mirrors live inputs in its top word
    mem_nxt[FBS_WORDS-1] = in_bits_in;
    unique case (st_r)
      FBS_S_RX: begin
        if (link.req_valid && link.req_ready) begin
          if (cnt_r < 9'd6) rq_nxt[cnt_r[2:0]] = link.req_data;
          // Serial and TCP framings both leave this much for the unit
          if (cnt_r == FBS_PDU_MAX) big_nxt = 1'b1;
          cnt_nxt = cnt_r + 9'd1;
          if (link.req_last) st_nxt = FBS_S_EXEC;
        end
      end
      FBS_S_EXEC: begin
        fc_nxt = rq_r[0];
        exc_nxt = 8'h00;
        a_nxt = ra;
        n_nxt = rn;
        ph_nxt = 3'd0;
        odd_nxt = 1'b0;
        st_nxt = FBS_S_TX;
        evc_nxt = evc_r + 16'h0001;
        unique case (rq_r[0])
          FBS_FC_RD_COILS, FBS_FC_RD_DISC: begin
            if (rn == 16'h0000 || rn > FBS_MAX_RD_BITS) exc_nxt = FBS_EXC_ILL_VAL;
            else if (re > FBS_BITS || re < ra) exc_nxt = FBS_EXC_ILL_ADDR;
            bc_nxt = 8'(({3'b000, rn} + 19'd7) >> 3);
          end
          FBS_FC_RD_HOLD, FBS_FC_RD_INREG: begin
            if (rn == 16'h0000 || rn > FBS_MAX_RD_REGS) exc_nxt = FBS_EXC_ILL_VAL;
            else if (re > 16'(FBS_WORDS) || re < ra) exc_nxt = FBS_EXC_ILL_ADDR;
            bc_nxt = 8'({rn[6:0], 1'b0});
          end
          FBS_FC_WR_COIL: begin
            if (rn != FBS_COIL_ON && rn != FBS_COIL_OFF) exc_nxt = FBS_EXC_ILL_VAL;
            else if (ra >= FBS_BITS) exc_nxt = FBS_EXC_ILL_ADDR;
            else mem_nxt[ra[7:4]][ra[3:0]] = rn[15];
          end
          FBS_FC_WR_REG: begin
            if (ra >= 16'(FBS_WORDS - 1)) exc_nxt = FBS_EXC_ILL_ADDR;
            else mem_nxt[ra[FBS_AW-1:0]] = rn;
          end
          FBS_FC_RD_EXCST: ;
          FBS_FC_DIAG: begin
            if (ra == FBS_SUB_CLRCNT) evc_nxt = 16'h0000;
            else if (ra == FBS_SUB_BUSCNT) n_nxt = evc_r;
            else if (ra != FBS_SUB_ECHO) exc_nxt = FBS_EXC_ILL_VAL;
          end
          default: begin
            // Custom codes answer with the event count; others refused
            if ((rq_r[0] >= FBS_FC_USR1_LO && rq_r[0] <= FBS_FC_USR1_HI) ||
                (rq_r[0] >= FBS_FC_USR2_LO && rq_r[0] <= FBS_FC_USR2_HI))
              n_nxt = evc_r;
            else exc_nxt = FBS_EXC_ILL_FUNC;
          end
        endcase
        if (big_r) exc_nxt = FBS_EXC_ILL_VAL;
      end
      FBS_S_TX: begin
        bv = 1'b1;
        if (exc_r != 8'h00) begin
          bd = (ph_r == 3'd0) ? (fc_r | FBS_FC_EXC_BIT) : exc_r;
          bl = (ph_r != 3'd0);
        end else begin
          unique case (ph_r)
            3'd0: bd = fc_r;
            3'd1: bd = (fc_r == FBS_FC_RD_EXCST) ? FBS_EXC_STATUS :
                       (fc_r <= FBS_FC_RD_INREG) ? bc_r : a_r[15:8];
            3'd2: bd = a_r[7:0];
            3'd3: bd = n_r[15:8];
            3'd4: bd = n_r[7:0];
            default: begin
              // Packed bits LSB-first, or words high byte first
              if (fc_r <= FBS_FC_RD_DISC) begin
                for (int k = 0; k < 8; k++)
                  bd[k] = (16'(k) < n_r) ? bit_at(mem_r, a_r + 16'(k)) : 1'b0;
              end else begin
                bd = odd_r ? mem_r[a_r[FBS_AW-1:0]][7:0]
                           : mem_r[a_r[FBS_AW-1:0]][15:8];
              end
            end
          endcase
          if (fc_r == FBS_FC_RD_EXCST) bl = (ph_r == 3'd1);
          else if (fc_r <= FBS_FC_RD_INREG)
            bl = (ph_r == 3'd5) && (bc_r == 8'd1);
          else bl = (ph_r == 3'd4);
        end
        if (brdy) begin
          if (bl) st_nxt = FBS_S_RX;
          if (fc_r <= FBS_FC_RD_INREG && exc_r == 8'h00 && ph_r == 3'd1)
            ph_nxt = 3'd5;
          else if (ph_r == 3'd5) begin
            bc_nxt = bc_r - 8'd1;
            if (fc_r <= FBS_FC_RD_DISC) begin
              a_nxt = a_r + 16'h0008;
              n_nxt = n_r - 16'h0008;
            end else begin
              odd_nxt = ~odd_r;
              if (odd_r) a_nxt = a_r + 16'h0001;
            end
          end else ph_nxt = ph_r + 3'd1;
          if (bl) begin
            cnt_nxt = 9'd0;
            big_nxt = 1'b0;
          end
        end
      end
      default: st_nxt = FBS_S_RX;
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= FBS_S_RX;
      cnt_r <= 9'd0;
      big_r <= 1'b0;
      evc_r <= 16'h0000;
      fc_r <= 8'h00;
      exc_r <= 8'h00;
      a_r <= 16'h0000;
      n_r <= 16'h0000;
      ph_r <= 3'd0;
      odd_r <= 1'b0;
      bc_r <= 8'h00;
      for (int i = 0; i < 6; i++) rq_r[i] <= 8'h00;
      for (int i = 0; i < FBS_WORDS; i++) mem_r[i] <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      big_r <= big_nxt;
      evc_r <= evc_nxt;
      fc_r <= fc_nxt;
      exc_r <= exc_nxt;
      a_r <= a_nxt;
      n_r <= n_nxt;
      ph_r <= ph_nxt;
      odd_r <= odd_nxt;
      bc_r <= bc_nxt;
      for (int i = 0; i < 6; i++) rq_r[i] <= rq_nxt[i];
      for (int i = 0; i < FBS_WORDS; i++) mem_r[i] <= mem_nxt[i];
    end
  end

  // Two-entry skid buffer: a stalled client loses no response byte
  logic [8:0] q_r [0:1];
  logic [8:0] q_nxt [0:1];
  logic [1:0] qn_r, qn_nxt;
  always_comb begin
    brdy = (qn_r != 2'd2);
    q_nxt[0] = q_r[0];
    q_nxt[1] = q_r[1];
    qn_nxt = qn_r;
    if (qn_r != 2'd0 && link.rsp_ready) begin
      q_nxt[0] = q_r[1];
      qn_nxt = qn_r - 2'd1;
    end
    if (bv && brdy) begin
      q_nxt[qn_nxt[0]] = {bl, bd};
      qn_nxt = qn_nxt + 2'd1;
    end
  end
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q_r[0] <= 9'h000;
      q_r[1] <= 9'h000;
      qn_r <= 2'd0;
    end else begin
      q_r[0] <= q_nxt[0];
      q_r[1] <= q_nxt[1];
      qn_r <= qn_nxt;
    end
  end

  logic rrdy_r, busy_r;
  logic [15:0] cw_r;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rrdy_r <= 1'b0;
      busy_r <= 1'b0;
      cw_r <= 16'h0000;
    end else begin
      // No new request while the last response byte still waits
      rrdy_r <= (st_nxt == FBS_S_RX) && (qn_nxt == 2'd0);
      busy_r <= (st_nxt != FBS_S_RX);
      cw_r <= mem_nxt[0];
    end
  end
  assign link.req_ready = rrdy_r;
  assign link.rsp_valid = (qn_r != 2'd0);
  assign link.rsp_data = q_r[0][7:0];
  assign link.rsp_last = q_r[0][8];
  assign coil_word_out = cw_r;
  assign busy_out = busy_r;
endmodule : fbs_server
`default_nettype wire

// ==== verilog/fbs_client.sv ====
/*
  Client end: sends one request unit from a five-byte user buffer and
  collects the response, with a response timeout.
  Assumes the server answers over the shared link interface.
*/
`timescale 1ns/1ps
`default_nettype none
module fbs_client
  import fbs_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  fbs_link_if.client       link,
  input  wire logic        start_in,
  input  wire logic [7:0]  fc_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] qty_in,
  input  wire logic [2:0]  len_in,
  output logic             done_out,
  output logic             exc_out,
  output logic [7:0]       exc_code_out,
  output logic             timeout_out,
  output logic [15:0]      last_word_out
);
  typedef enum logic [2:0] {
    FBS_C_IDLE = 3'b001,
    FBS_C_SEND = 3'b010,
    FBS_C_WAIT = 3'b100
  } fbs_cli_st_t;
  fbs_cli_st_t st_r, st_nxt;
  logic [7:0]  b_r [0:4];
  logic [7:0]  b_nxt [0:4];
  logic [2:0]  i_r, i_nxt, len_r, len_nxt;
  logic [15:0] t_r, t_nxt, w_r, w_nxt;
  logic [7:0]  x_r, x_nxt;
  logic        first_r, first_nxt, dn_r, dn_nxt, ex_r, ex_nxt, to_r, to_nxt;

  always_comb begin
    st_nxt = st_r;
    for (int k = 0; k < 5; k++) b_nxt[k] = b_r[k];
    i_nxt = i_r;
    len_nxt = len_r;
    t_nxt = t_r;
    w_nxt = w_r;
    x_nxt = x_r;
    first_nxt = first_r;
    dn_nxt = 1'b0;
    ex_nxt = ex_r;
    to_nxt = 1'b0;
    unique case (st_r)
      FBS_C_IDLE: begin
        // Code zero and exception-range codes are never sent
        if (start_in && fc_in != FBS_FC_NONE && !fc_in[7]) begin
          b_nxt[0] = fc_in;
          b_nxt[1] = addr_in[15:8];
          b_nxt[2] = addr_in[7:0];
          b_nxt[3] = qty_in[15:8];
          b_nxt[4] = qty_in[7:0];
          len_nxt = (len_in > 3'd5 || len_in == 3'd0) ? 3'd5 : len_in;
          i_nxt = 3'd0;
          st_nxt = FBS_C_SEND;
        end
      end
      FBS_C_SEND: begin
        if (link.req_ready) begin
          i_nxt = i_r + 3'd1;
          if (i_r + 3'd1 == len_r) begin
            st_nxt = FBS_C_WAIT;
            t_nxt = 16'(FBS_TMO_CYC);
            first_nxt = 1'b1;
            w_nxt = 16'h0000;
          end
        end
      end
      FBS_C_WAIT: begin
        t_nxt = t_r - 16'h0001;
        if (link.rsp_valid) begin
          first_nxt = 1'b0;
          if (first_r) ex_nxt = link.rsp_data[7];
          else begin
            x_nxt = link.rsp_data;
            w_nxt = {w_r[7:0], link.rsp_data};
          end
          if (link.rsp_last) begin
            dn_nxt = 1'b1;
            st_nxt = FBS_C_IDLE;
          end
        end else if (t_r == 16'h0000) begin
          to_nxt = 1'b1;
          st_nxt = FBS_C_IDLE;
        end
      end
      default: st_nxt = FBS_C_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= FBS_C_IDLE;
      for (int k = 0; k < 5; k++) b_r[k] <= 8'h00;
      i_r <= 3'd0;
      len_r <= 3'd0;
      t_r <= 16'h0000;
      w_r <= 16'h0000;
      x_r <= 8'h00;
      first_r <= 1'b0;
      dn_r <= 1'b0;
      ex_r <= 1'b0;
      to_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      for (int k = 0; k < 5; k++) b_r[k] <= b_nxt[k];
      i_r <= i_nxt;
      len_r <= len_nxt;
      t_r <= t_nxt;
      w_r <= w_nxt;
      x_r <= x_nxt;
      first_r <= first_nxt;
      dn_r <= dn_nxt;
      ex_r <= ex_nxt;
      to_r <= to_nxt;
    end
  end

  assign link.req_valid = (st_r == FBS_C_SEND);
  assign link.req_data = b_r[i_r];
  assign link.req_last = (i_r + 3'd1 == len_r);
  assign link.rsp_ready = (st_r == FBS_C_WAIT);
  assign done_out = dn_r;
  assign exc_out = ex_r;
  assign exc_code_out = x_r;
  assign timeout_out = to_r;
  assign last_word_out = w_r;
endmodule : fbs_client
`default_nettype wire

// ==== tb/fbs_link_checker.sv ====
/*
  Concurrent checks on the request/response link between client and server.
  Assumes one clock and the link signals handed in by name.
*/
`timescale 1ns/1ps
`default_nettype none
module fbs_link_checker
  import fbs_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       arst_n_in,
  input wire logic [7:0] req_data,
  input wire logic       req_valid,
  input wire logic       req_last,
  input wire logic       req_ready,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_valid,
  input wire logic       rsp_last,
  input wire logic       rsp_ready
);
  logic       req_hs;
  logic       rsp_hs;
  logic       first_r;
  logic       first_nxt;
  logic       pend_r;
  logic       pend_nxt;
  logic       exc_r;
  logic       exc_nxt;
  logic [7:0] fc_r;
  logic [7:0] fc_nxt;
  logic [8:0] idx_r;
  logic [8:0] idx_nxt;

  assign req_hs = req_valid & req_ready;
  assign rsp_hs = rsp_valid & rsp_ready;

  // Remembers the request code and where we are in the response
  always_comb begin
    first_nxt = req_hs ? req_last : first_r;
    fc_nxt    = (req_hs && first_r) ? req_data : fc_r;
    pend_nxt  = (req_hs && req_last) | (pend_r & ~(rsp_hs & rsp_last));
    idx_nxt   = rsp_hs ? (rsp_last ? 9'h000 : idx_r + 9'h001) : idx_r;
    exc_nxt   = (rsp_hs && idx_r == 9'h000) ? rsp_data[7] : exc_r;
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      first_r <= 1'b1;
      fc_r    <= 8'h00;
      pend_r  <= 1'b0;
      idx_r   <= 9'h000;
      exc_r   <= 1'b0;
    end else begin
      first_r <= first_nxt;
      fc_r    <= fc_nxt;
      pend_r  <= pend_nxt;
      idx_r   <= idx_nxt;
      exc_r   <= exc_nxt;
    end
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_head;
    rsp_hs && idx_r == 9'h000;
  endsequence
  sequence s_exc_head;
    rsp_hs && idx_r == 9'h000 && rsp_data[7];
  endsequence

  property p_echo_or_exc;
    s_head |-> (rsp_data == fc_r || rsp_data == (fc_r | 8'h80));
  endproperty
  a_echo_or_exc: assert property (p_echo_or_exc)
    else $error("response code neither echo nor exception form");
  property p_zero_code;
    s_head and (fc_r == 8'h00) |-> rsp_data == 8'h80;
  endproperty
  a_zero_code: assert property (p_zero_code)
    else $error("code zero not answered with exception");
  property p_exc_len;
    s_exc_head |-> ##[1:8] (rsp_hs && rsp_last);
  endproperty
  a_exc_len: assert property (p_exc_len)
    else $error("exception response did not close with its code byte");
  property p_exc_code;
    rsp_hs && idx_r == 9'h001 && exc_r |-> rsp_last &&
      rsp_data inside {8'h01, 8'h02, 8'h03};
  endproperty
  a_exc_code: assert property (p_exc_code)
    else $error("exception code byte wrong");
  property p_answer_time;
    req_hs && req_last |-> ##[2:5] rsp_valid;
  endproperty
  a_answer_time: assert property (p_answer_time)
    else $error("response did not start in time");
  property p_only_answer;
    rsp_valid |-> pend_r;
  endproperty
  a_only_answer: assert property (p_only_answer)
    else $error("response without a request");
  property p_refuse_busy;
    rsp_valid |-> !req_ready;
  endproperty
  a_refuse_busy: assert property (p_refuse_busy)
    else $error("request accepted while answering");
  property p_rsp_hold;
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) &&
      $stable(rsp_last);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold)
    else $error("response byte changed before it was taken");
  property p_rsp_size;
    rsp_hs |-> idx_r < FBS_PDU_MAX;
  endproperty
  a_rsp_size: assert property (p_rsp_size)
    else $error("response unit longer than allowed");
  property p_req_code;
    req_hs && first_r |-> req_data != 8'h00 && !req_data[7];
  endproperty
  a_req_code: assert property (p_req_code)
    else $error("client sent a reserved request code");
endmodule : fbs_link_checker
`default_nettype wire

// ==== tb/fbs_pdu_server_tb_top.sv ====
/*
  Testbench: client and server joined by one link, plus a second server
  fed by a raw byte driver that sends an oversize unit.
*/
`timescale 1ns/1ps
`default_nettype none
module fieldbus_pdu_server_tb_top
  import fbs_pkg::*;
;
  logic        clock_in;
  logic        arst_n_in;
  logic        start_in;
  logic [7:0]  fc_in;
  logic [15:0] addr_in;
  logic [15:0] qty_in;
  logic [2:0]  len_in;
  logic        done_out;
  logic        exc_out;
  logic [7:0]  exc_code_out;
  logic        timeout_out;
  logic [15:0] last_word_out;
  logic [15:0] coil_word_out;
  logic        tmo_seen;
  int          n_errors;
  int          cmp_count;
  logic [7:0]  rsp2[$];
  logic        busy_out;
  logic [7:0]  bad[4] = '{8'h2b, 8'h40, 8'h49, 8'h6f};
  logic [7:0]  nsend[3] = '{8'h00, 8'h85, 8'hff};
  logic [7:0]  usr[4] = '{8'h41, 8'h48, 8'h64, 8'h6e};

  fbs_link_if link();
  fbs_link_if link2();
  fbs_server fbs_server_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .link(link.server), .in_bits_in(16'ha5c3),
    .coil_word_out(coil_word_out), .busy_out(busy_out));
  fbs_client fbs_client_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .link(link.client), .start_in(start_in), .fc_in(fc_in),
    .addr_in(addr_in), .qty_in(qty_in), .len_in(len_in),
    .done_out(done_out), .exc_out(exc_out), .exc_code_out(exc_code_out),
    .timeout_out(timeout_out), .last_word_out(last_word_out));
  fbs_server fbs_server_raw_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .link(link2.server), .in_bits_in(16'h0000), .coil_word_out(),
    .busy_out());
  fbs_link_checker fbs_link_checker_i (.clock_in(clock_in),
    .arst_n_in(arst_n_in), .req_data(link.req_data),
    .req_valid(link.req_valid), .req_last(link.req_last),
    .req_ready(link.req_ready), .rsp_data(link.rsp_data),
    .rsp_valid(link.rsp_valid), .rsp_last(link.rsp_last),
    .rsp_ready(link.rsp_ready));

  always #20 clock_in = ~clock_in;

  always @(posedge clock_in) begin
    if (timeout_out === 1'b1) tmo_seen = 1'b1;
    if (link2.rsp_valid === 1'b1) rsp2.push_back(link2.rsp_data);
  end

  task automatic chk_w(input string what, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk_w

  task automatic chk_b(input string what, input logic e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask : chk_b

  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // One whole client transaction; results are read two cycles after done
  task automatic run(input logic [7:0] fc, input logic [15:0] a, q,
                     input logic [2:0] n);
    int k;
    @(negedge clock_in);
    fc_in    = fc;
    addr_in  = a;
    qty_in   = q;
    len_in   = n;
    start_in = 1'b1;
    @(negedge clock_in);
    start_in = 1'b0;
    k = 0;
    do begin
      @(posedge clock_in);
      #1;
      k++;
    end while (done_out !== 1'b1 && k < 400);
    chk_b("done_out", 1'b1, done_out);
    repeat (2) @(posedge clock_in);
    #1;
    chk_b("busy_out", 1'b0, busy_out);
  endtask : run

  task automatic expect_ok(input logic [15:0] w);
    chk_b("exc_out", 1'b0, exc_out);
    chk_w("last_word_out", w, last_word_out);
  endtask : expect_ok

  task automatic expect_exc(input logic [7:0] c);
    chk_b("exc_out", 1'b1, exc_out);
    chk_w("exc_code_out", {8'h00, c}, {8'h00, exc_code_out});
  endtask : expect_exc

  // Client must keep reserved codes off the link entirely
  task automatic refuse(input logic [7:0] fc);
    int k;
    @(negedge clock_in);
    fc_in    = fc;
    len_in   = 3'd5;
    start_in = 1'b1;
    k = 0;
    repeat (20) begin
      @(posedge clock_in);
      #1;
      if (link.req_valid !== 1'b0 || done_out !== 1'b0) k++;
    end
    @(negedge clock_in);
    start_in = 1'b0;
    chk_w("refused code activity", 16'h0000, 16'(k));
  endtask : refuse

  // Raw sender: holds each byte from a falling edge until ready is seen
  task automatic raw_req(input logic [7:0] fc, input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      @(negedge clock_in);
      link2.req_data  = (i == 0) ? fc : i[7:0];
      link2.req_valid = 1'b1;
      link2.req_last  = (i == n - 1);
      k = 0;
      do begin
        @(posedge clock_in);
        k++;
      end while (link2.req_ready !== 1'b1 && k < 100);
    end
    @(negedge clock_in);
    link2.req_valid = 1'b0;
    link2.req_last  = 1'b0;
    link2.req_data  = ~link2.req_data;
    repeat (30) @(posedge clock_in);
  endtask : raw_req

  initial begin
    repeat (20000) @(posedge clock_in);
    n_errors++;
    complete_run();
  end

  initial begin
    clock_in = 1'b0;
    arst_n_in = 1'b0;
    {start_in, fc_in, addr_in, qty_in, len_in} = '0;
    {link2.req_data, link2.req_valid, link2.req_last} = '0;
    link2.rsp_ready = 1'b1;
    tmo_seen = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (10) @(negedge clock_in);
    arst_n_in = 1'b1;
    repeat (3) @(negedge clock_in);
    run(FBS_FC_WR_REG, 16'h0002, 16'h1234, 3'd5);
    expect_ok(16'h1234);
    run(FBS_FC_RD_HOLD, 16'h0002, 16'h0001, 3'd5);
    expect_ok(16'h1234);
    // Coil numbered 4 travels as address 3
    run(FBS_FC_WR_COIL, 16'h0003, FBS_COIL_ON, 3'd5);
    chk_w("coil_word_out", 16'h0008, coil_word_out);
    run(FBS_FC_RD_HOLD, 16'h0000, 16'h0001, 3'd5);
    expect_ok(16'h0008);
    run(FBS_FC_RD_COILS, 16'h0000, 16'h0010, 3'd5);
    expect_ok(16'h0800);
    run(FBS_FC_RD_DISC, 16'h00f0, 16'h0010, 3'd5);
    expect_ok(16'hc3a5);
    run(FBS_FC_RD_INREG, 16'h000f, 16'h0001, 3'd5);
    expect_ok(16'ha5c3);
    run(FBS_FC_WR_REG, 16'h000f, 16'h5555, 3'd5);
    expect_exc(FBS_EXC_ILL_ADDR);
    run(FBS_FC_RD_HOLD, 16'h0010, 16'h0001, 3'd5);
    expect_exc(FBS_EXC_ILL_ADDR);
    run(FBS_FC_RD_HOLD, 16'h0000, FBS_MAX_RD_REGS + 16'h0001, 3'd5);
    expect_exc(FBS_EXC_ILL_VAL);
    run(FBS_FC_WR_COIL, 16'h0000, 16'h1234, 3'd5);
    expect_exc(FBS_EXC_ILL_VAL);
    run(FBS_FC_RD_EXCST, 16'h0000, 16'h0000, 3'd1);
    chk_w("exc_code_out", {8'h00, FBS_EXC_STATUS}, {8'h00, exc_code_out});
    run(FBS_FC_DIAG, FBS_SUB_ECHO, 16'habcd, 3'd5);
    expect_ok(16'habcd);
    run(FBS_FC_DIAG, 16'h00ff, 16'h0000, 3'd5);
    expect_exc(FBS_EXC_ILL_VAL);
    run(FBS_FC_DIAG, FBS_SUB_CLRCNT, 16'h0000, 3'd5);
    expect_ok(16'h0000);
    run(FBS_FC_DIAG, FBS_SUB_BUSCNT, 16'h0000, 3'd5);
    chk_b("count after clear small", 1'b1, last_word_out < 16'h0003);
    foreach (bad[i]) begin
      run(bad[i], 16'h0000, 16'h0001, 3'd5);
      expect_exc(FBS_EXC_ILL_FUNC);
    end
    foreach (nsend[i]) begin
      refuse(nsend[i]);
    end
    foreach (usr[i]) begin
      run(usr[i], 16'h0001, 16'h0000, 3'd3);
      chk_b("exc_out", 1'b0, exc_out);
    end
    // A bare zero code, sent past the client, must still be answered
    raw_req(FBS_FC_NONE, 1);
    chk_w("raw0 size", 16'h0002, 16'(rsp2.size()));
    chk_w("raw0 code", 16'h0080, {8'h00, rsp2[0]});
    chk_w("raw0 exc", {8'h00, FBS_EXC_ILL_FUNC}, {8'h00, rsp2[1]});
    rsp2.delete();
    raw_req(FBS_FC_WR_REGS, 254);
    chk_w("raw size", 16'h0002, 16'(rsp2.size()));
    chk_w("raw code", 16'h0090, {8'h00, rsp2[0]});
    chk_w("raw exc", {8'h00, FBS_EXC_ILL_VAL}, {8'h00, rsp2[1]});
    chk_b("timeout_out seen", 1'b0, tmo_seen);
    complete_run();
  end
endmodule : fieldbus_pdu_server_tb_top
`default_nettype wire
